// *** port_intensity_bank_low.sv ***
// serial register slave and modulators for the low eight ports
// Function
// - address 0x10 upper nibble is the port one duty field, bit 7 msb.
// - address 0x10 lower nibble is the port zero duty field, same coding.
// - duty code n from 0 to 14 sinks the port for n+1 of 16 slots.
// - duty code 1111 gives a static level with no modulation.
// - duty code 1101 gives fourteen sixteenths, steps are linear.
// - write with read/write bit 0, read back stored fields with bit 1.
// - address 0x11 holds port three upper and port two lower.
// - address 0x12 holds port five upper and port four lower.
// - address 0x13 holds port seven upper and port six lower.
// - omitted legacy features keep legacy power-up behaviour.
// - new features use only new addresses, legacy ones keep meaning.
// - master intensity zero stops the oscillator, all outputs static.
// - at power-up modulation and blink features are disabled.
`timescale 1ns/100ps
module port_intensity_bank_low
  import intensity_bank_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEFAULT,
  parameter int SLOT_CYCLES = PWM_SLOT_CYCLES
)(
  input wire logic clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [3:0] master_intensity,
  input wire logic [7:0] port_off_level,
  output logic port_output_data,
  output logic port_zero_output_oe,
  output logic port_one_output_oe,
  output logic port_two_output_oe,
  output logic port_three_output_oe,
  output logic port_four_output_oe,
  output logic port_five_output_oe,
  output logic port_six_output_oe,
  output logic port_seven_output_oe
);
  // true for the four addresses this bank answers on
  function automatic logic is_intensity(input logic [7:0] addr);
    is_intensity = (addr >= INTENSITY_ONE_ZERO_ADDR) &&
                   (addr <= INTENSITY_SEVEN_SIX_ADDR);
  endfunction : is_intensity

  // register index within the bank
  function automatic logic [1:0] bank_index(input logic [7:0] addr);
    logic [7:0] offset;
    offset = addr - INTENSITY_ONE_ZERO_ADDR;
    bank_index = offset[1:0];
  endfunction : bank_index

  logic [1:0] pins_sync;
  logic scl_s;
  logic sda_s;
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  slave_state_type state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [7:0] ptr_reg;
  logic rw_reg;
  logic sda_oe_reg;
  logic sda_out_reg;
  logic port_data_reg;
  logic wr_en;
  logic [7:0] rd_byte;
  logic [INTENSITY_COUNT-1:0][7:0] intensity_reg;
  logic [15:0] prescale_reg;
  logic [3:0] slot_reg;
  logic [3:0] phase_reg;
  logic run;
  logic master_on;
  logic [PORT_COUNT-1:0] port_oe;

  // clock and data pins pass the three-stage filter
  pin_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .clk(clk),
    .reset(reset),
    .pin_in({scl_in, sda_in}),
    .pin_out(pins_sync)
  );
  assign scl_s = pins_sync[1];
  assign sda_s = pins_sync[0];

  // previous filtered levels for edge and condition detection
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // bus events: data moving while the clock is high marks start or stop
  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;
  assign bus_start = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign bus_stop = scl_s && scl_d_reg && !sda_d_reg && sda_s;

  // write strobe at the clock fall after the eighth data bit
  assign wr_en = (state_reg == ST_WDATA) && scl_fall && (bit_cnt_reg == 4'h8);
  // readback byte; addresses outside the bank read as zero
  assign rd_byte = is_intensity(ptr_reg) ? intensity_reg[bank_index(ptr_reg)]
                                         : UNMAPPED_READ;

  // serial slave: address, command pointer, then data bytes
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end
    else if (bus_stop)
    begin
      state_reg <= ST_IDLE;
      sda_oe_reg <= 1'b0;
    end
    else if (bus_start)
    begin
      state_reg <= ST_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          sda_oe_reg <= 1'b0;
        end
        ST_ADDR, ST_CMD, ST_WDATA:
        begin
          if (scl_rise)
          begin
            shift_reg <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          else if (scl_fall && bit_cnt_reg == 4'h8)
          begin
            if (state_reg == ST_ADDR)
            begin
              if (shift_reg[7:1] == SLAVE_ADDR)
              begin
                rw_reg <= shift_reg[0];
                sda_oe_reg <= 1'b1;
                state_reg <= ST_ADDR_ACK;
              end
              else
                state_reg <= ST_IDLE;
            end
            else if (state_reg == ST_CMD)
            begin
              ptr_reg <= shift_reg;
              sda_oe_reg <= 1'b1;
              state_reg <= ST_CMD_ACK;
            end
            else
            begin
              ptr_reg <= ptr_reg + 8'h01;
              sda_oe_reg <= 1'b1;
              state_reg <= ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg)
            begin
              tx_reg <= rd_byte;
              sda_oe_reg <= !rd_byte[7];
              state_reg <= ST_RDATA;
            end
            else
            begin
              sda_oe_reg <= 1'b0;
              state_reg <= ST_CMD;
            end
          end
        end
        ST_CMD_ACK, ST_WDATA_ACK:
        begin
          if (scl_fall)
          begin
            bit_cnt_reg <= 4'h0;
            sda_oe_reg <= 1'b0;
            state_reg <= ST_WDATA;
          end
        end
        ST_RDATA:
        begin
          if (scl_rise)
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          else if (scl_fall)
          begin
            if (bit_cnt_reg == 4'h8)
            begin
              sda_oe_reg <= 1'b0;
              ptr_reg <= ptr_reg + 8'h01;
              state_reg <= ST_RACK;
            end
            else
            begin
              tx_reg <= {tx_reg[6:0], 1'b0};
              sda_oe_reg <= !tx_reg[6];
            end
          end
        end
        ST_RACK:
        begin
          // a high acknowledge bit ends the read
          if (scl_rise && sda_s)
            state_reg <= ST_IDLE;
          else if (scl_fall)
          begin
            bit_cnt_reg <= 4'h0;
            tx_reg <= rd_byte;
            sda_oe_reg <= !rd_byte[7];
            state_reg <= ST_RDATA;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // intensity registers; other addresses are left alone
  always_ff @(posedge clk)
  begin
    if (reset)
      intensity_reg <= {INTENSITY_COUNT{INTENSITY_RESET}};
    else if (wr_en && is_intensity(ptr_reg))
      intensity_reg[bank_index(ptr_reg)] <= shift_reg;
  end

  // open-drain data lines only ever pull low
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sda_out_reg <= 1'b0;
      port_data_reg <= 1'b0;
    end
    else
    begin
      sda_out_reg <= 1'b0;
      port_data_reg <= 1'b0;
    end
  end

  // modulation oscillator, held cleared while master intensity is zero
  assign run = (master_intensity != MASTER_OFF);
  assign master_on = (master_intensity == MASTER_FULL) ||
                     (phase_reg < master_intensity);

  always_ff @(posedge clk)
  begin
    if (reset || !run)
    begin
      prescale_reg <= 16'h0000;
      slot_reg <= 4'h0;
      phase_reg <= 4'h0;
    end
    else if (prescale_reg == 16'(SLOT_CYCLES - 1))
    begin
      prescale_reg <= 16'h0000;
      slot_reg <= slot_reg + 4'h1;
      if (slot_reg == SLOT_LAST)
        phase_reg <= (phase_reg == MASTER_LAST_PHASE) ? 4'h0
                                                      : phase_reg + 4'h1;
    end
    else
      prescale_reg <= prescale_reg + 16'h0001;
  end

  // one modulator per port; odd ports take the upper nibble
  generate
    for (genvar i = 0; i < PORT_COUNT; i++)
    begin : g_port
      localparam int FIELD_LSB = (i % 2 == 1) ? UPPER_FIELD_LSB
                                              : LOWER_FIELD_LSB;
      intensity_pwm u_pwm (
        .clk(clk),
        .reset(reset),
        .run(run),
        .master_on(master_on),
        .slot(slot_reg),
        .duty(intensity_reg[i / 2][FIELD_LSB +: FIELD_WIDTH]),
        .level(port_off_level[i]),
        .drive_oe(port_oe[i])
      );
    end
  endgenerate

  assign sda_out = sda_out_reg;
  assign sda_oe = sda_oe_reg;
  assign port_output_data = port_data_reg;
  assign port_zero_output_oe = port_oe[0];
  assign port_one_output_oe = port_oe[1];
  assign port_two_output_oe = port_oe[2];
  assign port_three_output_oe = port_oe[3];
  assign port_four_output_oe = port_oe[4];
  assign port_five_output_oe = port_oe[5];
  assign port_six_output_oe = port_oe[6];
  assign port_seven_output_oe = port_oe[7];

  AST_ONE_ZERO_UPPER:
    assert property (@(posedge clk) disable iff (reset)
      (wr_en && ptr_reg == INTENSITY_ONE_ZERO_ADDR)
      |=> intensity_reg[0][7:4] == $past(shift_reg[7:4]))
    else $error("port one field not stored in upper nibble of 0x10");

  AST_ONE_ZERO_LOWER:
    assert property (@(posedge clk) disable iff (reset)
      (wr_en && ptr_reg == INTENSITY_ONE_ZERO_ADDR)
      |=> intensity_reg[0][3:0] == $past(shift_reg[3:0]))
    else $error("port zero field not stored in lower nibble of 0x10");

  AST_THREE_TWO:
    assert property (@(posedge clk) disable iff (reset)
      (wr_en && ptr_reg == INTENSITY_THREE_TWO_ADDR)
      |=> intensity_reg[1] == $past(shift_reg))
    else $error("write to 0x11 not stored");

  AST_FIVE_FOUR:
    assert property (@(posedge clk) disable iff (reset)
      (wr_en && ptr_reg == INTENSITY_FIVE_FOUR_ADDR)
      |=> intensity_reg[2] == $past(shift_reg))
    else $error("write to 0x12 not stored");

  AST_SEVEN_SIX:
    assert property (@(posedge clk) disable iff (reset)
      (wr_en && ptr_reg == INTENSITY_SEVEN_SIX_ADDR)
      |=> intensity_reg[3] == $past(shift_reg))
    else $error("write to 0x13 not stored");

  AST_RETAIN:
    assert property (@(posedge clk) disable iff (reset)
      !wr_en |=> $stable(intensity_reg))
    else $error("intensity field changed without a write");

  AST_FOREIGN_ADDR:
    assert property (@(posedge clk) disable iff (reset)
      (wr_en && !is_intensity(ptr_reg)) |=> $stable(intensity_reg))
    else $error("write outside the bank altered a field");

  AST_POWER_UP:
    assert property (@(posedge clk)
      reset |=> intensity_reg == {INTENSITY_COUNT{INTENSITY_RESET}})
    else $error("fields not static after reset");

  AST_READBACK:
    assert property (@(posedge clk) disable iff (reset)
      (state_reg == ST_ADDR_ACK && scl_fall && rw_reg && !bus_start &&
       !bus_stop && is_intensity(ptr_reg))
      |=> tx_reg == intensity_reg[bank_index(ptr_reg)])
    else $error("readback byte differs from stored field");
endmodule : port_intensity_bank_low

// *** intensity_bank_pkg.sv ***
// shared constants and types for the low port intensity bank
package intensity_bank_pkg;
  // serial slave address, arbitrary value, overridden per board
  localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h20;
  // intensity register addresses on the serial bus
  localparam logic [7:0] INTENSITY_ONE_ZERO_ADDR = 8'h10;
  localparam logic [7:0] INTENSITY_THREE_TWO_ADDR = 8'h11;
  localparam logic [7:0] INTENSITY_FIVE_FOUR_ADDR = 8'h12;
  localparam logic [7:0] INTENSITY_SEVEN_SIX_ADDR = 8'h13;
  localparam int INTENSITY_COUNT = 4;
  localparam int PORT_COUNT = 8;
  // field layout: odd port in the upper nibble, even port in the lower
  localparam int UPPER_FIELD_LSB = 4;
  localparam int LOWER_FIELD_LSB = 0;
  localparam int FIELD_WIDTH = 4;
  // reset value: every field static, so modulation is off at power-up
  localparam logic [7:0] INTENSITY_RESET = 8'hff;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // duty and master codes
  localparam logic [3:0] DUTY_STATIC = 4'hf;
  localparam logic [3:0] MASTER_OFF = 4'h0;
  localparam logic [3:0] MASTER_FULL = 4'hf;
  localparam logic [3:0] MASTER_LAST_PHASE = 4'he;
  localparam logic [3:0] SLOT_LAST = 4'hf;
  // modulator slot time and its length in clock cycles
  localparam int CLK_PERIOD_NS = 25;
  localparam int PWM_SLOT_NS = 400;
  localparam int PWM_SLOT_CYCLES = PWM_SLOT_NS / CLK_PERIOD_NS;
  // serial slave states
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK
  } slave_state_type;
endpackage : intensity_bank_pkg

// *** pin_sync.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync
  import intensity_bank_pkg::*;
#(
  parameter int WIDTH = 2
)(
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] out_reg;

  // idle bus lines are high, so the chain resets high
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s1_reg <= '1;
      s2_reg <= '1;
      s3_reg <= '1;
      out_reg <= '1;
    end
    else
    begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // a bit changes only once stages two and three agree
      out_reg <= (s2_reg & s3_reg) | (out_reg & (s2_reg ^ s3_reg));
    end
  end

  assign pin_out = out_reg;
endmodule : pin_sync

// *** intensity_pwm.sv ***
// one open-drain port modulator
`timescale 1ns/100ps
module intensity_pwm
  import intensity_bank_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  input wire logic master_on,
  input wire logic [3:0] slot,
  input wire logic [3:0] duty,
  input wire logic level,
  output logic drive_oe
);
  logic drive_oe_reg;

  // level 0 sinks the pin; pwm only gates the sinking time
  always_ff @(posedge clk)
  begin
    if (reset)
      drive_oe_reg <= 1'b0;
    else if (!run || duty == DUTY_STATIC)
      drive_oe_reg <= !level;
    else
      drive_oe_reg <= master_on && (slot <= duty) && !level;
  end

  assign drive_oe = drive_oe_reg;

  AST_STATIC_CODE:
    assert property (@(posedge clk) disable iff (reset)
      (run && duty == DUTY_STATIC) |=> drive_oe_reg == !$past(level))
    else $error("static code did not give a static level");

  AST_OSC_STOPPED:
    assert property (@(posedge clk) disable iff (reset)
      (!run) [*2] |=> drive_oe_reg == !$past(level))
    else $error("stopped oscillator still modulates the port");

  AST_DUTY_WINDOW:
    assert property (@(posedge clk) disable iff (reset)
      (run && master_on && !level && duty != DUTY_STATIC)
      |=> drive_oe_reg == ($past(slot) <= $past(duty)))
    else $error("sink time does not match n plus one slots");

  AST_FOURTEEN:
    assert property (@(posedge clk) disable iff (reset)
      (run && master_on && !level && duty == 4'hd && slot == 4'he)
      |=> !drive_oe_reg)
    else $error("code 1101 sank for more than fourteen slots");
endmodule : intensity_pwm

// *** serial_host_model.sv ***
// two-wire serial bus host model for the intensity register bank
`timescale 1ns/100ps
module serial_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h20,
  parameter int HALF = 10
)(
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  // both lines released at idle, clock stands high between frames
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // one half phase of the bus clock, changes land on falling edges
  task automatic half;
    repeat (HALF) @(negedge clk);
  endtask : half
  // start or repeated start: data falls while the clock is high
  task automatic start;
    sda_drv = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_drv = 1'b0;
    half();
    scl = 1'b0;
    half();
  endtask : start
  // stop: data rises while the clock is high, then bus idles
  task automatic stop;
    sda_drv = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_drv = 1'b1;
    half();
  endtask : stop
  // data set during clock low, held over the whole high phase
  task automatic put_bit(input logic b);
    sda_drv = b;
    half();
    scl = 1'b1;
    half();
    scl = 1'b0;
    half();
  endtask : put_bit
  // line released, sampled late in the high phase
  task automatic get_bit(output logic b);
    sda_drv = 1'b1;
    half();
    scl = 1'b1;
    half();
    b = sda_line;
    scl = 1'b0;
    half();
  endtask : get_bit
  // byte out msb first, ack returned high when the device pulled low
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
      put_bit(d[i]);
    get_bit(b);
    ack = ~b;
  endtask : write_byte
  // byte in msb first, then host ack or nack on the last byte
  task automatic read_byte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      get_bit(d[i]);
    put_bit(last);
  endtask : read_byte
  // address byte with the read/write bit in the lsb
  task automatic addr(input logic rw, output logic ack);
    write_byte({DEV_ADDR, rw}, ack);
  endtask : addr
endmodule : serial_host_model

// *** tb_port_intensity_bank_low.sv ***
// self-checking testbench for the low port intensity bank
`timescale 1ns/100ps
module tb_port_intensity_bank_low
  import intensity_bank_pkg::*;
;
  localparam int SLOT = 2;
  localparam int FRAME = 16 * SLOT;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] master_intensity = MASTER_FULL;
  logic [7:0] port_off_level = 8'h0f;
  logic scl;
  logic sda_drv;
  logic sda_line;
  logic sda_out;
  logic sda_oe;
  logic port_output_data;
  logic [7:0] port_oe;
  int fail_count = 0;
  int checks = 0;
  int cnt [8];
  int frames = 1;
  logic [31:0] q;
  // pulled-up data line, low when either party pulls
  assign sda_line = sda_drv & ~sda_oe;
  always #12.5 clk = ~clk;
  port_intensity_bank_low #(
    .SLAVE_ADDR(SLAVE_ADDR_DEFAULT),
    .SLOT_CYCLES(SLOT)
  ) u_dut (
    .clk(clk),
    .reset(reset),
    .scl_in(scl),
    .sda_in(sda_line),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .master_intensity(master_intensity),
    .port_off_level(port_off_level),
    .port_output_data(port_output_data),
    .port_zero_output_oe(port_oe[0]),
    .port_one_output_oe(port_oe[1]),
    .port_two_output_oe(port_oe[2]),
    .port_three_output_oe(port_oe[3]),
    .port_four_output_oe(port_oe[4]),
    .port_five_output_oe(port_oe[5]),
    .port_six_output_oe(port_oe[6]),
    .port_seven_output_oe(port_oe[7])
  );
  serial_host_model #(
    .DEV_ADDR(SLAVE_ADDR_DEFAULT)
  ) u_host (
    .clk(clk),
    .sda_line(sda_line),
    .scl(scl),
    .sda_drv(sda_drv)
  );
  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // burst write of n bytes from the top of d, each byte acked
  task automatic wr(input logic [7:0] ptr, input logic [31:0] d, int n);
    logic a;
    u_host.start();
    u_host.addr(1'b0, a);
    check({7'h0, a}, 8'h01);
    u_host.write_byte(ptr, a);
    for (int i = 0; i < n; i++)
    begin
      u_host.write_byte(d[31 - 8 * i -: 8], a);
      check({7'h0, a}, 8'h01);
    end
    u_host.stop();
  endtask : wr
  // set pointer, repeated start, burst read of n bytes into q
  task automatic rd(input logic [7:0] ptr, int n);
    logic a;
    logic [7:0] b;
    u_host.start();
    u_host.addr(1'b0, a);
    u_host.write_byte(ptr, a);
    u_host.start();
    u_host.addr(1'b1, a);
    check({7'h0, a}, 8'h01);
    for (int i = 0; i < n; i++)
    begin
      u_host.read_byte(i == n - 1, b);
      q[31 - 8 * i -: 8] = b;
    end
    u_host.stop();
  endtask : rd
  // count sinking cycles of each port over frames modulation frames, one by default
  task automatic measure;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 8; i++)
      cnt[i] = 0;
    repeat (frames * FRAME)
    begin
      @(negedge clk);
      for (int i = 0; i < 8; i++)
        if (port_oe[i] === 1'b1)
          cnt[i]++;
    end
  endtask : measure
  // power-up: all fields static, ports follow the static level
  task automatic t_reset;
    rd(INTENSITY_ONE_ZERO_ADDR, 4);
    check(q[31:24] & q[23:16] & q[15:8] & q[7:0], 8'hff);
    check(q[31:24] | q[23:16] | q[15:8] | q[7:0], 8'hff);
    measure();
    for (int i = 0; i < 8; i++)
      check(8'(cnt[i]), i < 4 ? 8'h00 : 8'(FRAME));
    check({7'h0, sda_out}, 8'h00);
    check({7'h0, port_output_data}, 8'h00);
    $display("test reset done");
  endtask : t_reset
  // port i gets code i: field placement and linear duty steps
  task automatic t_map;
    port_off_level = 8'h00;
    wr(INTENSITY_ONE_ZERO_ADDR, 32'h10325476, 4);
    rd(INTENSITY_ONE_ZERO_ADDR, 4);
    check(q[31:24], 8'h10);
    check(q[23:16], 8'h32);
    check(q[15:8], 8'h54);
    check(q[7:0], 8'h76);
    measure();
    for (int i = 0; i < 8; i++)
      check(8'(cnt[i]), 8'((i + 1) * SLOT));
    $display("test map done");
  endtask : t_map
  // boundary codes: static, fourteen and fifteen sixteenths, one
  task automatic t_codes;
    wr(INTENSITY_ONE_ZERO_ADDR, 32'hdfe00000, 2);
    measure();
    check(8'(cnt[0]), 8'(FRAME));
    check(8'(cnt[1]), 8'(14 * SLOT));
    check(8'(cnt[2]), 8'(SLOT));
    check(8'(cnt[3]), 8'(15 * SLOT));
    port_off_level = 8'h01;
    measure();
    check(8'(cnt[0]), 8'h00);
    $display("test codes done");
  endtask : t_codes
  // master zero: every port static at its level despite duty codes
  task automatic t_master;
    master_intensity = MASTER_OFF;
    port_off_level = 8'haa;
    measure();
    for (int i = 0; i < 8; i++)
      check(8'(cnt[i]), port_off_level[i] ? 8'h00 : 8'(FRAME));
    // master five: ports four to seven sink in five frames of fifteen
    master_intensity = 4'h5;
    port_off_level = 8'h00;
    frames = 15;
    measure();
    for (int i = 4; i < 8; i++)
      check(8'(cnt[i]), 8'(5 * (i + 1) * SLOT));
    frames = 1;
    master_intensity = MASTER_FULL;
    $display("test master done");
  endtask : t_master
  // wrong device address ignored, legacy address reads zero
  task automatic t_refuse;
    logic a;
    u_host.start();
    u_host.write_byte({SLAVE_ADDR_DEFAULT ^ 7'h01, 1'b0}, a);
    check({7'h0, a}, 8'h00);
    u_host.write_byte(INTENSITY_ONE_ZERO_ADDR, a);
    u_host.write_byte(8'h00, a);
    u_host.stop();
    wr(8'h04, 32'h5a000000, 1);
    rd(8'h04, 1);
    check(q[31:24], UNMAPPED_READ);
    rd(INTENSITY_ONE_ZERO_ADDR, 1);
    check(q[31:24], 8'hdf);
    $display("test refuse done");
  endtask : t_refuse
  // counts, verdict and end of run
  task automatic end_sim;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  // main sequence
  initial
  begin
    repeat (2) @(negedge clk);
    reset = 1'b0;
    repeat (6) @(negedge clk);
    t_reset();
    t_map();
    t_codes();
    t_master();
    t_refuse();
    end_sim();
  end
  // watchdog well beyond the expected run of about 11700 cycles
  initial
  begin
    repeat (60000) @(posedge clk);
    fail_count++;
    end_sim();
  end
endmodule : tb_port_intensity_bank_low
